// [rtl/driver_fault_monitor.sv]
// The register offsets and the address-and-strobe port were left to the implementer.
module driver_fault_monitor
	import fault_mon_pkg::*;
#(
	parameter int TIMER_W = TIMER_W_DEF
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic bridge_disable_input,
	input wire logic temp_warn_pin,
	input wire logic temp_shut_pin,
	input wire logic volt_ok_a,
	input wire logic volt_ok_b,
	input wire logic hs_on_a,
	input wire logic hs_on_b,
	input wire logic polarity_a,
	input wire logic polarity_b,
	input wire logic chop_event_a,
	input wire logic chop_event_b,
	input wire logic current_low_a,
	input wire logic current_low_b,
	input wire logic target_missed_a,
	input wire logic target_missed_b,
	input wire logic fullstep_mode,
	input wire logic shift_in,
	output logic serial_out,
	output logic spi_ready,
	output logic bridge_en_a,
	output logic bridge_en_b,
	output logic chop_end_a,
	output logic chop_end_b,
	output logic [1:0] hs_gate_current
);
	typedef struct packed {
		logic [OFF_TIME_SETTING_W-1:0] off_time_setting;
		logic sdd;
		logic [1:0] dsel;
		slope_type slope;
		logic [CS_W-1:0] cs;
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
		logic [NSYNC-1:0] filt;
		logic [1:0] pol_prev;
		logic [1:0] chop_seen;
		logic [1:0] miss_seen;
		logic [1:0] ol;
		logic [1:0] gate_cur;
		logic [31:0] rdata;
		logic sout;
		logic ready;
	} mon_type;

	mon_type st_r;
	mon_type st_nxt;
	logic user_off;
	logic ot;
	logic warn;
	logic latched;
	logic drive_on;
	logic [1:0] pol;
	logic [1:0] pol_chg;
	logic [1:0] chop_ev;
	logic [1:0] cur_low;
	logic [1:0] missed;
	logic [1:0] trip;
	logic [1:0] block;
	logic [1:0] sflag;
	logic [TIMER_W-1:0] delay_cyc;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;

	if ((1 << TIMER_W) <= DLY_SEL0_CYC)
	begin : g_chk
		$error("driver_fault_monitor: TIMER_W too narrow for the longest delay");
	end

	// delay select decode
	function automatic logic [TIMER_W-1:0] delay_of(input logic [1:0] sel);
		case (sel)
			2'h0: delay_of = TIMER_W'(DLY_SEL0_CYC);
			2'h1: delay_of = TIMER_W'(DLY_SEL1_CYC);
			2'h2: delay_of = TIMER_W'(DLY_SEL2_CYC);
			default: delay_of = TIMER_W'(DLY_SEL3_CYC);
		endcase
	endfunction : delay_of

	// per coil inputs gathered so both coils share one loop
	assign pol = {polarity_b, polarity_a};
	assign chop_ev = {chop_event_b, chop_event_a};
	assign cur_low = {current_low_b, current_low_a};
	assign missed = {target_missed_b, target_missed_a};
	assign pol_chg = pol ^ st_r.pol_prev;

	// driver enable chain; filtered pins only, never the raw stages
	assign user_off = st_r.filt[SY_DIS] | (st_r.off_time_setting == '0);
	assign ot = st_r.filt[SY_SHUT];
	assign warn = st_r.filt[SY_WARN];
	assign latched = |sflag;
	assign drive_on = !user_off && !ot && !latched;
	assign delay_cyc = delay_of(st_r.dsel);

	// bridges drop in the same cycle as a trip; open load plays no part
	assign bridge_en_a = drive_on && !block[0];
	assign bridge_en_b = drive_on && !block[1];
	assign chop_end_a = trip[0];
	assign chop_end_b = trip[1];

	short_guard #(
		.TIMER_W(TIMER_W)
	) u_guard_a (
		.clk(clk),
		.rst_b(rst_b),
		.driver_off(user_off),
		.detect_off(st_r.sdd),
		.delay_cyc(delay_cyc),
		.hs_on(hs_on_a),
		.volt_ok(st_r.filt[SY_VOKA]),
		.pol_change(pol_chg[0]),
		.trip(trip[0]),
		.bridge_block(block[0]),
		.short_flag(sflag[0])
	);

	short_guard #(
		.TIMER_W(TIMER_W)
	) u_guard_b (
		.clk(clk),
		.rst_b(rst_b),
		.driver_off(user_off),
		.detect_off(st_r.sdd),
		.delay_cyc(delay_cyc),
		.hs_on(hs_on_b),
		.volt_ok(st_r.filt[SY_VOKB]),
		.pol_change(pol_chg[1]),
		.trip(trip[1]),
		.bridge_block(block[1]),
		.short_flag(sflag[1])
	);

	// register images
	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[OFF_TIME_SETTING_LSB +: OFF_TIME_SETTING_W] = st_r.off_time_setting;
		ctrl_word[SDD_BIT] = st_r.sdd;
		ctrl_word[DSEL_LSB +: 2] = st_r.dsel;
		ctrl_word[SLOPE_LSB +: 2] = st_r.slope;
		ctrl_word[CS_LSB +: CS_W] = st_r.cs;
		status_word = '0;
		status_word[ST_SFA_BIT] = sflag[0];
		status_word[ST_SFB_BIT] = sflag[1];
		status_word[ST_OLA_BIT] = st_r.ol[0];
		status_word[ST_OLB_BIT] = st_r.ol[1];
		status_word[ST_OVERTEMP_WARNING_FLAG_BIT] = warn;
		status_word[ST_OT_BIT] = ot;
		status_word[ST_CS_LSB +: CS_W] = st_r.cs;
	end

	// next state
	always_comb
	begin
		st_nxt = st_r;
		// three stage pin sync; a change counts when stages two and three agree
		st_nxt.s1 = {volt_ok_b, volt_ok_a, temp_shut_pin, temp_warn_pin, bridge_disable_input};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < NSYNC; i++)
		begin
			if (st_r.s2[i] == st_r.s3[i])
			begin
				st_nxt.filt[i] = st_r.s3[i];
			end
		end
		// open load: judged over each constant polarity period
		for (int i = 0; i < 2; i++)
		begin
			if (pol_chg[i])
			begin
				if (drive_on && !cur_low[i])
				begin
					st_nxt.ol[i] = !st_r.chop_seen[i]
						|| (fullstep_mode && st_r.miss_seen[i]);
				end
				// an event in the toggle cycle belongs to the new period
				st_nxt.chop_seen[i] = chop_ev[i];
				st_nxt.miss_seen[i] = missed[i];
			end
			else
			begin
				st_nxt.chop_seen[i] = st_r.chop_seen[i] | chop_ev[i];
				st_nxt.miss_seen[i] = st_r.miss_seen[i] | missed[i];
			end
		end
		st_nxt.pol_prev = pol;
		// compensated modes step one notch up above the warning level
		st_nxt.gate_cur = st_r.slope;
		if (warn && (st_r.slope == SLP_MIN_TC || st_r.slope == SLP_MED_TC))
		begin
			st_nxt.gate_cur = st_r.slope + 2'h1;
		end
		// register writes
		if (wr_en && addr == ADDR_CTRL)
		begin
			st_nxt.off_time_setting = wdata[OFF_TIME_SETTING_LSB +: OFF_TIME_SETTING_W];
			st_nxt.sdd = wdata[SDD_BIT];
			st_nxt.dsel = wdata[DSEL_LSB +: 2];
			st_nxt.slope = slope_type'(wdata[SLOPE_LSB +: 2]);
			st_nxt.cs = wdata[CS_LSB +: CS_W];
		end
		// read data stand for exactly one cycle; unmapped reads give zero
		st_nxt.rdata = '0;
		if (rd_en)
		begin
			case (addr)
				ADDR_CTRL: st_nxt.rdata = ctrl_word;
				ADDR_STATUS: st_nxt.rdata = status_word;
				default: st_nxt.rdata = '0;
			endcase
		end
		st_nxt.sout = shift_in;
		st_nxt.ready = 1'b1;
	end

	// the supply monitor reset clears every bit, settings included
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	assign serial_out = st_r.sout;
	assign spi_ready = st_r.ready;
	assign hs_gate_current = st_r.gate_cur;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_latch;
		latched |-> !bridge_en_a && !bridge_en_b;
	endproperty
	a_latch: assert property (p_latch) else $error("bridge on after latch");

	property p_flagclr;
		user_off |=> !sflag[0] && !sflag[1];
	endproperty
	a_flagclr: assert property (p_flagclr) else $error("short flag kept while off");

	property p_ot;
		ot |-> !bridge_en_a && !bridge_en_b && status_word[ST_OT_BIT];
	endproperty
	a_ot: assert property (p_ot) else $error("driver on in overtemperature");

	property p_warn;
		$rose(st_r.s3[SY_WARN]) && st_r.s2[SY_WARN] |=> status_word[ST_OVERTEMP_WARNING_FLAG_BIT];
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag missed");

	property p_slope;
		warn && (st_r.slope == SLP_MIN_TC || st_r.slope == SLP_MED_TC)
			|=> hs_gate_current == $past(st_r.slope) + 2'h1;
	endproperty
	a_slope: assert property (p_slope) else $error("gate current not raised");

	property p_olhold;
		pol_chg[0] && current_low_a |=> $stable(st_r.ol[0]);
	endproperty
	a_olhold: assert property (p_olhold) else $error("open load moved at low current");

	property p_olset;
		pol_chg[0] && drive_on && !current_low_a && !st_r.chop_seen[0] |=> st_r.ol[0];
	endproperty
	a_olset: assert property (p_olset) else $error("open load not set");

	property p_olkeep;
		!pol_chg[0] |=> $stable(st_r.ol[0]);
	endproperty
	a_olkeep: assert property (p_olkeep) else $error("open load moved without toggle");

	property p_uvreset;
		disable iff (1'b0)
		!rst_b |=> st_r == '0 && !serial_out && !spi_ready && rdata == '0;
	endproperty
	a_uvreset: assert property (p_uvreset) else $error("state kept through reset");

	property p_cszero;
		$rose(rst_b) |-> status_word[ST_CS_LSB +: CS_W] == '0;
	endproperty
	a_cszero: assert property (p_cszero) else $error("current scale not cleared");

	// coil b runs the same loop body, so coil a stands for both here
	property p_ready;
		rst_b |=> spi_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("serial unit not ready");

	property p_olfull;
		pol_chg[0] && drive_on && !current_low_a && fullstep_mode && st_r.miss_seen[0]
			|=> st_r.ol[0];
	endproperty
	a_olfull: assert property (p_olfull) else $error("missed target not flagged");

	property p_olclr;
		pol_chg[0] && drive_on && !current_low_a && st_r.chop_seen[0]
			&& !(fullstep_mode && st_r.miss_seen[0]) |=> !st_r.ol[0];
	endproperty
	a_olclr: assert property (p_olclr) else $error("open load kept");

	property p_gatekeep;
		!warn |=> hs_gate_current == $past(st_r.slope);
	endproperty
	a_gatekeep: assert property (p_gatekeep) else $error("gate current raised");
endmodule : driver_fault_monitor

// [rtl/fault_mon_pkg.sv]
package fault_mon_pkg;
	// system clock period
	localparam int CLK_NS = 5;
	// short detection delay choices, as times
	localparam int DLY_SEL0_NS = 3200;
	localparam int DLY_SEL1_NS = 1600;
	localparam int DLY_SEL2_NS = 1200;
	localparam int DLY_SEL3_NS = 800;
	// least times round up to whole cycles
	localparam int DLY_SEL0_CYC = (DLY_SEL0_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLY_SEL1_CYC = (DLY_SEL1_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLY_SEL2_CYC = (DLY_SEL2_NS + CLK_NS - 1) / CLK_NS;
	localparam int DLY_SEL3_CYC = (DLY_SEL3_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIMER_W_DEF = 10;
	// short counter ceiling that latches the bridges off
	localparam logic [1:0] SHORT_LIMIT = 2'h3;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// control word fields
	localparam int OFF_TIME_SETTING_LSB = 0;
	localparam int OFF_TIME_SETTING_W = 4;
	localparam int SDD_BIT = 4;
	localparam int DSEL_LSB = 5;
	localparam int SLOPE_LSB = 7;
	localparam int CS_LSB = 9;
	localparam int CS_W = 5;
	// status word fields
	localparam int ST_SFA_BIT = 0;
	localparam int ST_SFB_BIT = 1;
	localparam int ST_OLA_BIT = 2;
	localparam int ST_OLB_BIT = 3;
	localparam int ST_OVERTEMP_WARNING_FLAG_BIT = 4;
	localparam int ST_OT_BIT = 5;
	localparam int ST_CS_LSB = 6;
	// pin synchroniser lanes
	localparam int NSYNC = 5;
	localparam int SY_DIS = 0;
	localparam int SY_WARN = 1;
	localparam int SY_SHUT = 2;
	localparam int SY_VOKA = 3;
	localparam int SY_VOKB = 4;
	// high side slope modes
	typedef enum logic [1:0] {
		SLP_MIN = 2'h0,
		SLP_MIN_TC = 2'h1,
		SLP_MED_TC = 2'h2,
		SLP_MAX = 2'h3
	} slope_type;
endpackage : fault_mon_pkg

// [rtl/short_guard.sv]
module short_guard
	import fault_mon_pkg::*;
#(
	parameter int TIMER_W = TIMER_W_DEF
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic driver_off,
	input wire logic detect_off,
	input wire logic [TIMER_W-1:0] delay_cyc,
	input wire logic hs_on,
	input wire logic volt_ok,
	input wire logic pol_change,
	output logic trip,
	output logic bridge_block,
	output logic short_flag
);
	typedef struct packed {
		logic [TIMER_W-1:0] timer;
		logic fired;
		logic [1:0] cnt;
		logic flag;
	} guard_type;

	guard_type st_r;
	guard_type st_nxt;
	logic inc;
	logic dec;

	if ((1 << TIMER_W) <= DLY_SEL0_CYC)
	begin : g_chk
		$error("short_guard: TIMER_W too narrow for the longest delay");
	end

	// on phase timer, one trip per on phase, persistence counter
	always_comb
	begin
		st_nxt = st_r;
		trip = 1'b0;
		if (!hs_on)
		begin
			st_nxt.timer = '0;
			st_nxt.fired = 1'b0;
		end
		else if (!detect_off && !st_r.fired && !volt_ok)
		begin
			if (st_r.timer == delay_cyc)
			begin
				trip = 1'b1;
				st_nxt.fired = 1'b1;
			end
			else
			begin
				st_nxt.timer = st_r.timer + 1'b1;
			end
		end
		inc = trip;
		dec = pol_change && (st_r.cnt != 2'h0);
		if (inc && !dec && (st_r.cnt != SHORT_LIMIT))
		begin
			st_nxt.cnt = st_r.cnt + 2'h1;
		end
		else if (dec && !inc)
		begin
			st_nxt.cnt = st_r.cnt - 2'h1;
		end
		// flag only once the short has persisted to the limit
		st_nxt.flag = st_r.flag | (st_nxt.cnt == SHORT_LIMIT);
		if (driver_off)
		begin
			st_nxt = '0;
			trip = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// the bridge drops in the trip cycle itself, then stays off for the phase
	assign bridge_block = trip | st_r.fired;
	assign short_flag = st_r.flag;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_inc;
		trip && !pol_change && (st_r.cnt != SHORT_LIMIT) |=> st_r.cnt == $past(st_r.cnt) + 2'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("short count not raised");

	property p_dec;
		pol_change && !trip && !driver_off && (st_r.cnt != 2'h0)
			|=> st_r.cnt == $past(st_r.cnt) - 2'h1;
	endproperty
	a_dec: assert property (p_dec) else $error("short count not lowered");

	property p_floor;
		pol_change && !trip && (st_r.cnt == 2'h0) |=> st_r.cnt == 2'h0;
	endproperty
	a_floor: assert property (p_floor) else $error("short count below zero");

	property p_nodetect;
		detect_off |-> !trip;
	endproperty
	a_nodetect: assert property (p_nodetect) else $error("trip while disabled");

	property p_persist;
		$rose(short_flag) |-> st_r.cnt == SHORT_LIMIT;
	endproperty
	a_persist: assert property (p_persist) else $error("flag before limit");

	property p_late;
		trip |-> $past(hs_on, 1) && $past(!volt_ok, 1) && !volt_ok;
	endproperty
	a_late: assert property (p_late) else $error("trip without low voltage");
endmodule : short_guard

// [verif/coil_bridge_model.sv]
module coil_bridge_model
(
	input wire logic clk,
	input wire logic hs_on,
	input wire logic bridge_en,
	input wire logic shorted,
	output logic volt_ok
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] ramp_r;
	// a healthy coil node climbs to the detection level a few cycles into the on phase;
	// a short holds it down for as long as the bridge conducts
	always_ff @(posedge clk)
	begin
		if (hs_on && bridge_en && !shorted)
		begin
			if (ramp_r != 4'hF)
				ramp_r <= ramp_r + 4'h1;
		end
		else
			ramp_r <= 4'h0;
	end
	// slope shorter than every detection delay, so a healthy coil never trips
	assign volt_ok = (ramp_r >= 4'h4);
endmodule : coil_bridge_model

// [verif/tb.sv]
module tb
	import fault_mon_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] M_SFA = 32'h1 << ST_SFA_BIT;
	localparam logic [31:0] M_OLA = 32'h1 << ST_OLA_BIT;
	localparam logic [31:0] M_WARN = 32'h1 << ST_OVERTEMP_WARNING_FLAG_BIT;
	localparam logic [31:0] M_SHUT = 32'h1 << ST_OT_BIT;
	localparam logic [31:0] CS5 = 32'h5 << ST_CS_LSB;
	localparam logic [31:0] M_CS = ((32'h1 << CS_W) - 32'h1) << ST_CS_LSB;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wr_en = 1'b0, rd_en = 1'b0, dis_pin = 1'b0, warn_pin = 1'b0, shut_pin = 1'b0;
	logic hs_a = 1'b0, pol_a = 1'b0, chop_a = 1'b0, low_a = 1'b0, miss_a = 1'b0;
	logic full = 1'b0, sin = 1'b1, short_a = 1'b0, hs_b = 1'b0;
	logic vok_a, vok_b, sout, rdy, ben_a, ben_b, cend_a, cend_b;
	logic [1:0] hs_cur;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int dly [4] = '{DLY_SEL0_CYC, DLY_SEL1_CYC, DLY_SEL2_CYC, DLY_SEL3_CYC};

	always #2.5 clk = ~clk;

	driver_fault_monitor driver_fault_monitor_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.bridge_disable_input(dis_pin), .temp_warn_pin(warn_pin), .temp_shut_pin(shut_pin),
		.volt_ok_a(vok_a), .volt_ok_b(vok_b), .hs_on_a(hs_a), .hs_on_b(hs_b),
		.polarity_a(pol_a), .polarity_b(1'b0), .chop_event_a(chop_a), .chop_event_b(1'b0),
		.current_low_a(low_a), .current_low_b(1'b0), .target_missed_a(miss_a),
		.target_missed_b(1'b0), .fullstep_mode(full), .shift_in(sin), .serial_out(sout),
		.spi_ready(rdy), .bridge_en_a(ben_a), .bridge_en_b(ben_b), .chop_end_a(cend_a),
		.chop_end_b(cend_b), .hs_gate_current(hs_cur));
	coil_bridge_model coil_a_model (.clk(clk), .hs_on(hs_a), .bridge_en(ben_a),
		.shorted(short_a), .volt_ok(vok_a));
	coil_bridge_model coil_b_model (.clk(clk), .hs_on(hs_b), .bridge_en(ben_b),
		.shorted(1'b0), .volt_ok(vok_b));

	task conclude;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task chk_pin(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask : chk_pin

	function automatic logic [31:0] ctrl(input logic [3:0] off_time_setting, input logic sdd,
		input logic [1:0] sel);
		return (32'h5 << CS_LSB) | (32'h1 << SLOPE_LSB) | (32'(sel) << DSEL_LSB)
			| (32'(sdd) << SDD_BIT) | (32'(off_time_setting) << OFF_TIME_SETTING_LSB);
	endfunction : ctrl

	task wr(input logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= ADDR_CTRL;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe; the closing edge still sees them
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		chk_reg(rdata & mask, exp);
	endtask : rd

	// one high-side on phase on coil a; d < 0 means no trip is allowed
	task trip(input int d);
		int n;
		n = 0;
		@(posedge clk);
		hs_a <= 1'b1;
		@(posedge clk);
		#1;
		while (cend_a !== 1'b1 && n < 900)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (d < 0)
			chk_pin(cend_a, 1'b0);
		else
		begin
			chk_pin(n >= d - 1 && n <= d + 8, 1'b1);
			chk_pin(ben_a, 1'b0);
		end
		@(posedge clk);
		hs_a <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : trip

	task tog;
		@(posedge clk);
		pol_a <= ~pol_a;
		repeat (3) @(posedge clk);
	endtask : tog

	// pins pass a three stage filter, so give them time to land
	task settle;
		repeat (6) @(posedge clk);
	endtask : settle

	// hang guard: the whole sequence needs well under half of this
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			num_errors++;
			conclude;
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		chk_pin(sout, 1'b0);
		chk_pin(rdy, 1'b0);
		chk_pin(ben_a, 1'b0);
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		chk_pin(rdy, 1'b1);
		chk_pin(sout, 1'b1);
		rd(ADDR_STATUS, 32'h0, '1);
		rd(ADDR_CTRL, 32'h0, '1);
		rd(8'h08, 32'h0, '1);
		wr(ctrl(4'h1, 1'b0, 2'h3));
		rd(ADDR_CTRL, ctrl(4'h1, 1'b0, 2'h3), '1);
		rd(ADDR_STATUS, CS5, '1);
		settle;
		chk_pin(ben_a & ben_b, 1'b1);
		chk_reg(32'(hs_cur), 32'h1);
		warn_pin <= 1'b1;
		settle;
		chk_reg(32'(hs_cur), 32'h2);
		rd(ADDR_STATUS, M_WARN, M_WARN);
		warn_pin <= 1'b0;
		shut_pin <= 1'b1;
		settle;
		chk_pin(ben_a, 1'b0);
		rd(ADDR_STATUS, M_SHUT, M_SHUT);
		shut_pin <= 1'b0;
		settle;
		chk_pin(ben_a, 1'b1);
		short_a <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			wr(ctrl(4'h1, 1'b0, 2'(s)));
			trip(dly[s]);
			tog;
		end
		trip(dly[3]);
		trip(dly[3]);
		rd(ADDR_STATUS, 32'h0, M_SFA);
		trip(dly[3]);
		rd(ADDR_STATUS, M_SFA, M_SFA);
		chk_pin(ben_a | ben_b, 1'b0);
		wr(ctrl(4'h0, 1'b0, 2'h3));
		rd(ADDR_STATUS, 32'h0, M_SFA);
		chk_pin(ben_a, 1'b0);
		wr(ctrl(4'h1, 1'b0, 2'h3));
		settle;
		chk_pin(ben_a & ben_b, 1'b1);
		// healthy coil b climbs in time, so its guard must stay quiet for the phase
		hs_b <= 1'b1;
		repeat (200) @(posedge clk);
		chk_pin(cend_b | !ben_b, 1'b0);
		hs_b <= 1'b0;
		trip(dly[3]);
		trip(dly[3]);
		rd(ADDR_STATUS, 32'h0, M_SFA);
		dis_pin <= 1'b1;
		settle;
		chk_pin(ben_a, 1'b0);
		dis_pin <= 1'b0;
		settle;
		wr(ctrl(4'h1, 1'b1, 2'h3));
		trip(-1);
		short_a <= 1'b0;
		tog;
		tog;
		rd(ADDR_STATUS, M_OLA, M_OLA);
		@(posedge clk);
		chop_a <= 1'b1;
		@(posedge clk);
		chop_a <= 1'b0;
		rd(ADDR_STATUS, M_OLA, M_OLA);
		tog;
		rd(ADDR_STATUS, 32'h0, M_OLA);
		low_a <= 1'b1;
		tog;
		rd(ADDR_STATUS, 32'h0, M_OLA);
		low_a <= 1'b0;
		full <= 1'b1;
		miss_a <= 1'b1;
		chop_a <= 1'b1;
		@(posedge clk);
		chop_a <= 1'b0;
		tog;
		rd(ADDR_STATUS, M_OLA, M_OLA);
		chk_pin(ben_a, 1'b1);
		// supply dip in mid run: host finds the scale at zero and sets up again
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chk_pin(sout | rdy, 1'b0);
		rst_b <= 1'b1;
		rd(ADDR_STATUS, 32'h0, M_CS);
		wr(ctrl(4'h1, 1'b0, 2'h3));
		rd(ADDR_STATUS, CS5, M_CS);
		chk_pin(ben_a, 1'b1);
		conclude;
	end
endmodule : tb
